// [snvc_pkg.sv]
// Constants and types for the shadowed nonvolatile RAM host controller
// Functional notes
// - Chip select low for every access; high means idle standby.
// - Read: select and drive low, write strobe and nv select high.
// - Write: select and write strobe low, nv select high, data driven.
// - Recall: read pattern with nv select low; array copied into RAM.
// - Host holds store-blocking levels during power-up and power-down.
// - Store: select, strobe, nv select low, drive high; bus floats.
// - RAM usable after 100 us; nonvolatile usable after 5 ms.
`default_nettype none
package snvc_pkg;
  localparam int CLK_MHZ = 100;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int ACC_NS = 300;
  localparam int ACC_CYC = (ACC_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_NS = 40;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int NV_OP_MS = 5;
  localparam int NV_OP_CYC = NV_OP_MS * 1000 * CLK_MHZ;
  localparam int PUR_US = 100;
  localparam int PUR_CYC = PUR_US * CLK_MHZ;
  localparam int PUW_MS = 5;
  localparam int PUW_CYC = PUW_MS * 1000 * CLK_MHZ;
  localparam int CNT_W = 24;
  typedef enum logic [2:0] {
    SNVC_READ, SNVC_WRITE, SNVC_STORE, SNVC_RECALL, SNVC_NONE
  } snvc_cmd_t;
endpackage : snvc_pkg
`default_nettype wire

// [snvc_sync.sv]
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module snvc_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic o;
  } snvc_sync_t;
  snvc_sync_t st, next_st;
  always_comb begin
    next_st = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    if (st.s2 == st.s3) begin
      next_st.o = st.s3;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.o;
endmodule : snvc_sync
`default_nettype wire

// [snvc_host.sv]
// Host controller driving a shadowed nonvolatile RAM through its pins
`timescale 1ns/1ns
`default_nettype none
module snvc_host #(
  parameter int PUR_CYCLES = snvc_pkg::PUR_CYC,
  parameter int PUW_CYCLES = snvc_pkg::PUW_CYC,
  parameter int NV_CYCLES = snvc_pkg::NV_OP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // User command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire snvc_pkg::snvc_cmd_t cmd_op,
  input wire logic [snvc_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [snvc_pkg::DATA_W-1:0] cmd_wdata,
  output logic rsp_valid,
  output logic [snvc_pkg::DATA_W-1:0] rsp_rdata,
  output logic rsp_refused,
  // Supply status
  input wire logic supply_ok,
  output logic ram_avail,
  output logic nv_avail,
  output logic nv_busy,
  // Device pins
  output logic chip_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic nonvolatile_select_n,
  output logic [snvc_pkg::ADDR_W-1:0] addr_bus,
  input wire logic [snvc_pkg::DATA_W-1:0] data_bus_in,
  output logic [snvc_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe_n
);
  import snvc_pkg::*;
  typedef enum logic [2:0] {
    S_PWR, S_IDLE, S_RD, S_WR, S_NVP, S_WAIT, S_DONE
  } snvc_state_t;
  typedef struct packed {
    snvc_state_t fsm;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] pwr;
    logic wrote;
    logic cs_n;
    logic oe_n;
    logic we_n;
    logic ne_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic doe_n;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic refused;
  } snvc_host_t;
  snvc_host_t st, next_st;
  logic supply_s;
  genvar gi;
  logic [DATA_W-1:0] din_s;
  snvc_sync u_sup (
    .clk(clk),
    .arst_n(arst_n),
    .din(supply_ok),
    .dout(supply_s)
  );
  generate
    for (gi = 0; gi < DATA_W; gi++) begin : g_din
      snvc_sync u_d (
        .clk(clk),
        .arst_n(arst_n),
        .din(data_bus_in[gi]),
        .dout(din_s[gi])
      );
    end
  endgenerate
  logic pur_ok;
  logic puw_ok;
  assign pur_ok = st.pwr >= CNT_W'(PUR_CYCLES);
  assign puw_ok = st.pwr >= CNT_W'(PUW_CYCLES);
  always_comb begin
    next_st = st;
    next_st.rvalid = 1'b0;
    next_st.refused = 1'b0;
    if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
    if (!puw_ok) begin
      next_st.pwr = st.pwr + 1'b1;
    end
    case (st.fsm)
      S_PWR: begin
        // Store-blocking levels held throughout power-up
        next_st.cs_n = 1'b1;
        next_st.oe_n = 1'b0;
        next_st.we_n = 1'b1;
        next_st.ne_n = 1'b1;
        next_st.doe_n = 1'b1;
        if (supply_s && pur_ok) begin
          next_st.fsm = S_IDLE;
        end
      end
      S_IDLE: begin
        next_st.cs_n = 1'b1;
        next_st.oe_n = 1'b1;
        next_st.we_n = 1'b1;
        next_st.ne_n = 1'b1;
        next_st.doe_n = 1'b1;
        if (cmd_valid) begin
          next_st.addr = cmd_addr;
          next_st.dout = cmd_wdata;
          case (cmd_op)
            SNVC_READ: begin
              next_st.cs_n = 1'b0;
              next_st.oe_n = 1'b0;
              next_st.cnt = CNT_W'(ACC_CYC);
              next_st.fsm = S_RD;
            end
            SNVC_WRITE: begin
              next_st.cs_n = 1'b0;
              next_st.we_n = 1'b0;
              next_st.doe_n = 1'b0;
              next_st.cnt = CNT_W'(ACC_CYC);
              next_st.fsm = S_WR;
            end
            SNVC_STORE: begin
              if (!puw_ok || !st.wrote) begin
                next_st.refused = 1'b1;
                next_st.fsm = S_DONE;
              end else begin
                next_st.cs_n = 1'b0;
                next_st.we_n = 1'b0;
                next_st.ne_n = 1'b0;
                next_st.oe_n = 1'b1;
                next_st.wrote = 1'b0;
                next_st.cnt = CNT_W'(PULSE_CYC);
                next_st.fsm = S_NVP;
              end
            end
            SNVC_RECALL: begin
              if (!puw_ok) begin
                next_st.refused = 1'b1;
                next_st.fsm = S_DONE;
              end else begin
                next_st.cs_n = 1'b0;
                next_st.oe_n = 1'b0;
                next_st.ne_n = 1'b0;
                next_st.cnt = CNT_W'(PULSE_CYC);
                next_st.fsm = S_NVP;
              end
            end
            default: begin
              next_st.refused = 1'b1;
              next_st.fsm = S_DONE;
            end
          endcase
        end
      end
      S_RD: begin
        if (st.cnt == '0) begin
          next_st.rdata = din_s;
          next_st.cs_n = 1'b1;
          next_st.oe_n = 1'b1;
          next_st.fsm = S_DONE;
        end
      end
      S_WR: begin
        if (st.cnt == '0) begin
          next_st.we_n = 1'b1;
          next_st.cs_n = 1'b1;
          next_st.wrote = 1'b1;
          next_st.fsm = S_DONE;
        end
      end
      S_NVP: begin
        if (st.cnt == '0) begin
          next_st.cs_n = 1'b1;
          next_st.oe_n = 1'b1;
          next_st.we_n = 1'b1;
          next_st.ne_n = 1'b1;
          next_st.cnt = CNT_W'(NV_CYCLES);
          next_st.fsm = S_WAIT;
        end
      end
      S_WAIT: begin
        if (st.cnt == '0) begin
          next_st.fsm = S_DONE;
        end
      end
      S_DONE: begin
        next_st.doe_n = 1'b1;
        next_st.rvalid = 1'b1;
        // Refusal flag stands with the response
        next_st.refused = st.refused;
        next_st.fsm = S_IDLE;
      end
      default: begin
        next_st.fsm = S_IDLE;
      end
    endcase
    // Supply loss drops everything back to power-up
    if (!supply_s) begin
      next_st.fsm = S_PWR;
      next_st.pwr = '0;
      next_st.cs_n = 1'b1;
      next_st.oe_n = 1'b0;
      next_st.we_n = 1'b1;
      next_st.ne_n = 1'b1;
      next_st.doe_n = 1'b1;
      next_st.wrote = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '{fsm: S_PWR, cs_n: 1'b1, we_n: 1'b1, ne_n: 1'b1,
              doe_n: 1'b1, default: '0};
    end else begin
      st <= next_st;
    end
  end
  assign cmd_ready = (st.fsm == S_IDLE) && supply_s;
  assign rsp_valid = st.rvalid;
  assign rsp_rdata = st.rdata;
  assign rsp_refused = st.refused;
  assign ram_avail = (st.fsm != S_PWR);
  assign nv_avail = puw_ok && (st.fsm != S_PWR);
  assign nv_busy = (st.fsm == S_NVP) || (st.fsm == S_WAIT);
  assign chip_select_n = st.cs_n;
  assign output_drive_n = st.oe_n;
  assign write_strobe_n = st.we_n;
  assign nonvolatile_select_n = st.ne_n;
  assign addr_bus = st.addr;
  assign data_bus_out = st.dout;
  assign data_bus_oe_n = st.doe_n;

  chk_store_oe_high: assert property (@(posedge clk) disable iff (!arst_n)
    (!st.ne_n && !st.we_n && !st.cs_n) |-> st.oe_n)
    else $error("store pattern with output drive low");
  chk_bus_no_fight: assert property (@(posedge clk) disable iff (!arst_n)
    !st.doe_n |-> st.oe_n)
    else $error("host drives bus while device may drive");
  chk_read_levels: assert property (@(posedge clk) disable iff (!arst_n)
    (st.fsm == S_RD) |-> (!st.cs_n && !st.oe_n && st.we_n && st.ne_n))
    else $error("bad read levels");
  chk_write_levels: assert property (@(posedge clk) disable iff (!arst_n)
    (st.fsm == S_WR) |-> (!st.cs_n && !st.we_n && st.ne_n && !st.doe_n))
    else $error("bad write levels");
  chk_nv_pulse_len: assert property (@(posedge clk) disable iff (!arst_n)
    ($fell(st.ne_n) && supply_s) |-> !st.ne_n [*4])
    else $error("nonvolatile pulse too short");
  chk_store_needs_wr: assert property (@(posedge clk) disable iff (!arst_n)
    ($fell(st.ne_n) && !st.we_n) |-> $past(st.wrote))
    else $error("store without prior write");
  chk_store_clears: assert property (@(posedge clk) disable iff (!arst_n)
    ($fell(st.ne_n) && !st.we_n) |-> !st.wrote)
    else $error("write record not cleared");
  chk_busy_ready: assert property (@(posedge clk) disable iff (!arst_n)
    nv_busy |-> !cmd_ready)
    else $error("ready during nonvolatile operation");
  chk_supply_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !supply_s |=> (st.cs_n && st.fsm == S_PWR))
    else $error("activity with supply low");
  chk_idle_cs: assert property (@(posedge clk) disable iff (!arst_n)
    (st.fsm == S_IDLE) |-> st.cs_n)
    else $error("chip select low while idle");
endmodule : snvc_host
`default_nettype wire

// [snvc_dev.sv]
// Behavioural model of the shadowed nonvolatile RAM device
`timescale 1ns/1ns
`default_nettype none
module snvc_dev #(
  parameter int OP_NS = 200
) (
  // Supply
  input wire logic supply_ok,
  // Control pins
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic nonvolatile_select_n,
  input wire logic [snvc_pkg::ADDR_W-1:0] addr_bus,
  // Data bus
  input wire logic [snvc_pkg::DATA_W-1:0] host_data,
  input wire logic host_oe_n,
  output logic [snvc_pkg::DATA_W-1:0] data_bus,
  output logic dev_drive
);
  import snvc_pkg::*;
  logic [DATA_W-1:0] ram [512];
  logic [DATA_W-1:0] nv [512];
  logic [DATA_W-1:0] last;
  logic written, busy, wr_on, st_on, rc_on, act;
  time t_st, t_rc;
  initial begin
    written = 1'b0;
    busy = 1'b0;
    last = 8'h00;
  end
  assign act = supply_ok && !busy && !chip_select_n;
  assign dev_drive = act && !output_drive_n && nonvolatile_select_n
    && write_strobe_n;
  assign wr_on = act && !write_strobe_n && nonvolatile_select_n;
  assign st_on = act && !write_strobe_n && !nonvolatile_select_n
    && output_drive_n;
  assign rc_on = act && !output_drive_n && !nonvolatile_select_n
    && write_strobe_n;
  // Released bus shows the inverse of the last byte the device drove
  assign data_bus = !host_oe_n ? host_data :
    dev_drive ? ram[addr_bus] : ~last;
  always @(negedge dev_drive) last = ram[addr_bus];
  always @* begin
    if (wr_on) begin
      ram[addr_bus] = host_data;
      written = 1'b1;
    end
  end
  always @(posedge supply_ok) ram = nv;
  always @(posedge st_on) t_st = $time;
  always @(negedge st_on) begin
    if (supply_ok && $time - t_st >= 20 && written) begin
      busy = 1'b1;
      #(OP_NS);
      nv = ram;
      written = 1'b0;
      busy = 1'b0;
    end
  end
  always @(posedge rc_on) t_rc = $time;
  always @(negedge rc_on) begin
    if (supply_ok && $time - t_rc >= 20) begin
      busy = 1'b1;
      #(OP_NS);
      ram = nv;
      busy = 1'b0;
    end
  end
endmodule : snvc_dev
`default_nettype wire

// [snvc_host_bench.sv]
// Self-checking bench for the nonvolatile RAM host controller
`timescale 1ns/1ns
`default_nettype none
module snvc_host_bench;
  import snvc_pkg::*;
  localparam int NV = 30;
  localparam int RW = ACC_CYC + 3;
  localparam int NVL = PULSE_CYC + NV + 4;
  logic clk, arst_n, cmd_valid, cmd_ready, rsp_valid, rsp_refused;
  logic supply_ok, ram_avail, nv_avail, nv_busy, cs_n, od_n, ws_n, ns_n;
  logic doe_n, dev_drive, rf;
  snvc_cmd_t cmd_op;
  logic [ADDR_W-1:0] cmd_addr, addr_bus;
  logic [DATA_W-1:0] cmd_wdata, rsp_rdata, dbi, dbo, rd;
  int n_fail = 0;
  int compares = 0;
  int busy_cyc = 0;
  `define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    n_fail++; $display("[FAIL] %s exp %h got %h", nm, exp, got); end end
  snvc_host #(.PUR_CYCLES(20), .PUW_CYCLES(50), .NV_CYCLES(NV)) i_snvc_host (
    .clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_refused(rsp_refused), .supply_ok(supply_ok),
    .ram_avail(ram_avail), .nv_avail(nv_avail), .nv_busy(nv_busy),
    .chip_select_n(cs_n), .output_drive_n(od_n), .write_strobe_n(ws_n),
    .nonvolatile_select_n(ns_n), .addr_bus(addr_bus),
    .data_bus_in(dbi), .data_bus_out(dbo), .data_bus_oe_n(doe_n));
  snvc_dev i_snvc_dev (
    .supply_ok(supply_ok), .chip_select_n(cs_n), .output_drive_n(od_n),
    .write_strobe_n(ws_n), .nonvolatile_select_n(ns_n),
    .addr_bus(addr_bus), .host_data(dbo), .host_oe_n(doe_n),
    .data_bus(dbi), .dev_drive(dev_drive));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(negedge clk) begin
    if (nv_busy === 1'b1) busy_cyc++;
    if (arst_n && !doe_n && dev_drive) begin
      n_fail++;
      $display("[FAIL] bus_clash exp 0 got 1");
    end
  end
  task automatic end_sim();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic do_cmd(input snvc_cmd_t op, input logic [8:0] a,
      input logic [7:0] d, input int lat);
    int n;
    @(posedge clk);
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    n = 0;
    do begin @(negedge clk); n++; end while (cmd_ready !== 1'b1 && n < 900);
    if (cmd_ready !== 1'b1) begin
      n_fail++;
      end_sim();
    end
    @(posedge clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin @(negedge clk); n++; end while (rsp_valid !== 1'b1 && n < 900);
    if (n >= 900) begin
      n_fail++;
      end_sim();
    end
    `CHK("latency", lat, n)
    rd = rsp_rdata;
    rf = rsp_refused;
  endtask : do_cmd
  function automatic logic [7:0] pat(input logic [8:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : pat
  task automatic t_powerup();
    do_cmd(SNVC_STORE, 9'h000, 8'h00, 2);
    `CHK("early_store", 1'b1, rf)
    `CHK("ram_up", 1'b1, ram_avail)
    do_cmd(SNVC_READ, 9'h1ff, 8'h00, RW);
    `CHK("pu_recall", pat(9'h1ff), rd)
  endtask : t_powerup
  task automatic t_ram();
    logic [8:0] al [4] = '{9'h000, 9'h001, 9'h100, 9'h1ff};
    foreach (al[i]) do_cmd(SNVC_WRITE, al[i], ~pat(al[i]), RW);
    foreach (al[i]) begin
      do_cmd(SNVC_READ, al[i], 8'h00, RW);
      `CHK("ram_rd", ~pat(al[i]), rd)
    end
  endtask : t_ram
  task automatic t_store();
    int n;
    int b0;
    n = 0;
    while (nv_avail !== 1'b1 && n < 900) begin @(negedge clk); n++; end
    `CHK("nv_avail", 1'b1, nv_avail)
    b0 = busy_cyc;
    do_cmd(SNVC_STORE, 9'h000, 8'h00, NVL);
    `CHK("busy_len", PULSE_CYC + NV + 2, busy_cyc - b0)
    `CHK("store_ok", 1'b0, rf)
    `CHK("nv_copy", ~pat(9'h100), i_snvc_dev.nv[9'h100])
    do_cmd(SNVC_STORE, 9'h000, 8'h00, 2);
    `CHK("store_again", 1'b1, rf)
  endtask : t_store
  task automatic t_recall();
    do_cmd(SNVC_WRITE, 9'h1ff, 8'h3c, RW);
    do_cmd(SNVC_RECALL, 9'h000, 8'h00, NVL);
    `CHK("recall_ok", 1'b0, rf)
    do_cmd(SNVC_READ, 9'h1ff, 8'h00, RW);
    `CHK("recall_rd", ~pat(9'h1ff), rd)
    do_cmd(SNVC_NONE, 9'h000, 8'h00, 2);
    `CHK("none_ref", 1'b1, rf)
  endtask : t_recall
  task automatic t_supply();
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    `CHK("ready_low", 1'b0, cmd_ready)
    `CHK("ram_avail", 1'b0, ram_avail)
    `CHK("cs_idle", 1'b1, cs_n)
    `CHK("pu_block", 1'b0, od_n)
    @(posedge clk);
    supply_ok <= 1'b1;
    do_cmd(SNVC_READ, 9'h100, 8'h00, RW);
    `CHK("pu_again", ~pat(9'h100), rd)
  endtask : t_supply
  initial begin
    arst_n = 1'b0;
    supply_ok = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = SNVC_NONE;
    cmd_addr = 9'h000;
    cmd_wdata = 8'h00;
    for (int i = 0; i < 512; i++) i_snvc_dev.nv[i] = pat(9'(i));
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    supply_ok <= 1'b1;
    t_powerup();
    t_ram();
    t_store();
    t_recall();
    t_supply();
    end_sim();
  end
endmodule : snvc_host_bench
`default_nettype wire
